// >>> design/srci_regs.vh
// Register map, field layout and timing constants of the sequence run control block
// Behaviour
// - Sequence commands only while output on
// - Start command enters Run
// - Stop command enters Idle
// - Hold command pauses, keeps step
// - Branch jumps to destination, else ignored
// - Separate stored sequence per regulation mode
// - Clear writes default values to memory
// - Keep-type step holds previous level
// - Jump destination until jump count exhausted
// - Branch trigger ends step time immediately
// - External inputs sampled every 2 ms
// - External inputs only when enabled
// - Status outputs updated every 0.1 ms
// - Power-state status output
// - Output-state status output
// - Overload status output
// - Controller-busy status output
// - Sync code bits on two lines
// - Falling edges switch output off/on
// - Falling edges start, stop, hold
// - Falling edges trigger branch 0/1
// - Idle drives sync code zero
// - Termination chooses continue, idle, hold
// - Jump count 0 is unlimited
// - Branch destination 0 disables branching
`ifndef SRCI_REGS_VH
`define SRCI_REGS_VH

`define SRCI_ADDR_W 8
// Register offsets
`define SRCI_REG_CTRL 8'h00
`define SRCI_REG_CMD 8'h04
`define SRCI_REG_BRANCH 8'h08
`define SRCI_REG_STATUS 8'h0c
`define SRCI_REG_STEP 8'h10
`define SRCI_REG_LEVEL 8'h14
`define SRCI_REG_MEM_ADDR 8'h18
`define SRCI_REG_MEM_DATA 8'h1c
`define SRCI_REG_LAST_STEP 8'h20
// CTRL fields
`define SRCI_CTRL_EXT_EN 0
`define SRCI_CTRL_CC_MODE 1
`define SRCI_CTRL_BUSY 2
`define SRCI_CTRL_RESET 32'h0000_0000
// CMD fields (write one to act)
`define SRCI_CMD_OUT_OFF 0
`define SRCI_CMD_OUT_ON 1
`define SRCI_CMD_START 2
`define SRCI_CMD_STOP 3
`define SRCI_CMD_HOLD 4
`define SRCI_CMD_BR_ZERO 5
`define SRCI_CMD_BR_ONE 6
`define SRCI_CMD_CLEAR 7
// BRANCH fields
`define SRCI_BR0_LSB 0
`define SRCI_BR1_LSB 8
// Step word layout: time[15:0] level[31:16] dest[39:32] cnt[49:40] sync[51:50]
// keep[52] term[54:53]
`define SRCI_STEP_W 55
`define SRCI_F_TIME_LSB 0
`define SRCI_F_LEVEL_LSB 16
`define SRCI_F_DEST_LSB 32
`define SRCI_F_CNT_LSB 40
`define SRCI_F_SYNC_LSB 50
`define SRCI_F_KEEP 52
`define SRCI_F_TERM_LSB 53
// Default step: time 1 tick, level 0, continue
`define SRCI_STEP_DEFAULT 55'h00_0000_0000_0001
// Termination codes
`define SRCI_TERM_NEXT 2'h0
`define SRCI_TERM_STOP 2'h1
`define SRCI_TERM_HOLD 2'h2
// Timing
`define SRCI_CLK_HZ 250000000
`define SRCI_SAMPLE_US 2000
`define SRCI_STATUS_US 100
`define SRCI_SAMPLE_CYC ((`SRCI_CLK_HZ / 1000000) * `SRCI_SAMPLE_US)
`define SRCI_STATUS_CYC ((`SRCI_CLK_HZ / 1000000) * `SRCI_STATUS_US)

`endif

// >>> design/srci_step_mem.v
// Step program memory with registered read data
`default_nettype none
module srci_step_mem #(
  parameter AW = 9,
  parameter DW = 55
) (
  input wire clk_sys,
  input wire we,
  input wire [AW-1:0] waddr,
  input wire [DW-1:0] wdata,
  input wire [AW-1:0] raddr,
  output reg [DW-1:0] rdata
);
  reg [DW-1:0] mem [0:(1<<AW)-1];

  always @(posedge clk_sys) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata <= mem[raddr];
  end
endmodule // srci_step_mem
`default_nettype wire

// >>> design/srci_seq_ctrl.v
// Sequence run control and external control port
//
// Our own choices: the address map and the address-and-strobe port.
`include "srci_regs.vh"
`default_nettype none
module srci_seq_ctrl #(
  parameter SAMPLE_CYC = `SRCI_SAMPLE_CYC,
  parameter STATUS_CYC = `SRCI_STATUS_CYC,
  parameter TICK_CYC = 250000
) (
  input wire clk_sys,
  input wire rstn,
  input wire [7:0] addr,
  input wire [31:0] wdata,
  input wire wr_stb,
  input wire rd_stb,
  output reg [31:0] rdata_ff,
  input wire [6:0] ext_in,
  input wire power_on,
  input wire overload,
  output reg power_state_ff,
  output reg output_state_ff,
  output reg overload_state_ff,
  output reg busy_state_ff,
  output reg sync_bit_low_line_ff,
  output reg sync_bit_high_line_ff,
  output reg output_enable_ff,
  output reg [15:0] level_ff,
  output reg [1:0] seq_state_ff
);
  localparam ST_IDLE = 2'h0;
  localparam ST_RUN = 2'h1;
  localparam ST_HOLD = 2'h2;
  localparam ST_LOAD = 2'h3;
  localparam AW = 9;
  localparam [31:0] SAMPLE_MAX = SAMPLE_CYC - 1;
  localparam [31:0] STATUS_MAX = STATUS_CYC - 1;
  localparam [31:0] TICK_MAX = TICK_CYC - 1;

  reg [2:0] ctrl_ff;
  reg [7:0] br0_ff;
  reg [7:0] br1_ff;
  reg [7:0] last_step_ff;
  reg [AW-1:0] mem_addr_ff;
  reg [7:0] step_ff;
  reg [7:0] nxt_step;
  reg [15:0] time_ff;
  reg [1:0] sync_ff;
  reg [9:0] jump_used [0:255];
  reg [31:0] samp_cnt_ff;
  reg [31:0] stat_cnt_ff;
  reg [31:0] tick_cnt_ff;
  reg [6:0] s1_ff;
  reg [6:0] s2_ff;
  reg [6:0] s3_ff;
  reg [6:0] prev_ff;
  reg [6:0] fall_ff;
  reg clr_busy_ff;
  reg [7:0] clr_idx_ff;
  reg [2:0] pwr_sync_ff;
  reg [2:0] ovl_sync_ff;
  wire [54:0] step_word;
  wire cmd_wr = wr_stb && (addr == `SRCI_REG_CMD);
  wire ext_en = ctrl_ff[`SRCI_CTRL_EXT_EN];
  wire [6:0] ext_ev = ext_en ? fall_ff : 7'h00;
  wire do_off = (cmd_wr && wdata[`SRCI_CMD_OUT_OFF]) || ext_ev[0];
  wire do_on = (cmd_wr && wdata[`SRCI_CMD_OUT_ON]) || ext_ev[1];
  wire seq_ok = output_enable_ff && !clr_busy_ff;
  wire do_start = seq_ok && ((cmd_wr && wdata[`SRCI_CMD_START]) || ext_ev[2]);
  wire do_stop = seq_ok && ((cmd_wr && wdata[`SRCI_CMD_STOP]) || ext_ev[3]);
  wire do_hold = seq_ok && ((cmd_wr && wdata[`SRCI_CMD_HOLD]) || ext_ev[4]);
  wire do_br0 = seq_ok && ((cmd_wr && wdata[`SRCI_CMD_BR_ZERO]) || ext_ev[5]);
  wire do_br1 = seq_ok && ((cmd_wr && wdata[`SRCI_CMD_BR_ONE]) || ext_ev[6]);
  wire do_clear = cmd_wr && wdata[`SRCI_CMD_CLEAR] && seq_state_ff == ST_IDLE;
  wire tick = (tick_cnt_ff == TICK_MAX);
  wire [7:0] dest = step_word[`SRCI_F_DEST_LSB +: 8];
  wire [9:0] jcnt = step_word[`SRCI_F_CNT_LSB +: 10];
  wire [1:0] term = step_word[`SRCI_F_TERM_LSB +: 2];
  wire mem_wr = wr_stb && (addr == `SRCI_REG_MEM_DATA) && !clr_busy_ff;
  wire bank = ctrl_ff[`SRCI_CTRL_CC_MODE];
  wire [AW-1:0] w_addr = clr_busy_ff ? {bank, clr_idx_ff} : mem_addr_ff;
  wire [54:0] w_data = clr_busy_ff ? `SRCI_STEP_DEFAULT : {wdata[22:0], 32'h0000_0000};
  reg [31:0] mem_lo_ff;
  wire [54:0] w_full = clr_busy_ff ? w_data : {w_data[54:32], mem_lo_ff};

  srci_step_mem #(
    .AW(AW),
    .DW(`SRCI_STEP_W)
  ) u_mem (
    .clk_sys(clk_sys),
    .we(mem_wr || clr_busy_ff),
    .waddr(w_addr),
    .wdata(w_full),
    .raddr({bank, nxt_step}),
    .rdata(step_word)
  );

  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      samp_cnt_ff <= 32'h0000_0000;
      pwr_sync_ff <= 3'h0;
      ovl_sync_ff <= 3'h0;
      s1_ff <= 7'h7f;
      s2_ff <= 7'h7f;
      s3_ff <= 7'h7f;
      prev_ff <= 7'h7f;
      fall_ff <= 7'h00;
    end else begin
      pwr_sync_ff <= {pwr_sync_ff[1:0], power_on};
      ovl_sync_ff <= {ovl_sync_ff[1:0], overload};
      s1_ff <= ext_in;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      fall_ff <= 7'h00;
      if (samp_cnt_ff == SAMPLE_MAX) begin
        samp_cnt_ff <= 32'h0000_0000;
        if (s2_ff == s3_ff) begin
          prev_ff <= s3_ff;
          fall_ff <= prev_ff & ~s3_ff;
        end
      end else begin
        samp_cnt_ff <= samp_cnt_ff + 32'h0000_0001;
      end
    end
  end

  // Step time base
  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      tick_cnt_ff <= 32'h0000_0000;
    end else if (tick || seq_state_ff != ST_RUN) begin
      tick_cnt_ff <= 32'h0000_0000;
    end else begin
      tick_cnt_ff <= tick_cnt_ff + 32'h0000_0001;
    end
  end

  // Control and bus registers
  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      ctrl_ff <= 3'h0;
      br0_ff <= 8'h00;
      br1_ff <= 8'h00;
      last_step_ff <= 8'h01;
      mem_addr_ff <= {AW{1'b0}};
      mem_lo_ff <= 32'h0000_0000;
      output_enable_ff <= 1'b0;
      clr_busy_ff <= 1'b0;
      clr_idx_ff <= 8'h00;
    end else begin
      if (wr_stb) begin
        case (addr)
          `SRCI_REG_CTRL: ctrl_ff <= wdata[2:0];
          `SRCI_REG_BRANCH: begin
            br0_ff <= wdata[`SRCI_BR0_LSB +: 8];
            br1_ff <= wdata[`SRCI_BR1_LSB +: 8];
          end
          `SRCI_REG_LAST_STEP: last_step_ff <= wdata[7:0];
          `SRCI_REG_MEM_ADDR: mem_addr_ff <= wdata[AW-1:0];
          `SRCI_REG_LEVEL: mem_lo_ff <= wdata;
          default: ;
        endcase
      end
      if (mem_wr) begin
        mem_addr_ff <= mem_addr_ff + {{(AW-1){1'b0}}, 1'b1};
      end
      if (do_off) begin
        output_enable_ff <= 1'b0;
      end else if (do_on) begin
        output_enable_ff <= 1'b1;
      end
      if (do_clear) begin
        clr_busy_ff <= 1'b1;
        clr_idx_ff <= 8'h00;
      end else if (clr_busy_ff) begin
        clr_idx_ff <= clr_idx_ff + 8'h01;
        if (clr_idx_ff == 8'hff) begin
          clr_busy_ff <= 1'b0;
        end
      end
    end
  end

  // Next step selection, also drives memory read address
  always @* begin
    nxt_step = step_ff;
    if (do_br0 && br0_ff != 8'h00 && seq_state_ff != ST_IDLE) begin
      nxt_step = br0_ff;
    end else if (do_br1 && br1_ff != 8'h00 && seq_state_ff != ST_IDLE) begin
      nxt_step = br1_ff;
    end else if (do_start && seq_state_ff == ST_IDLE) begin
      nxt_step = 8'h01;
    end else if (seq_state_ff == ST_RUN && tick && time_ff <= 16'h0001) begin
      if (dest != 8'h00 && (jcnt == 10'h000 || jump_used[step_ff] < jcnt)) begin
        nxt_step = dest;
      end else if (step_ff != last_step_ff) begin
        nxt_step = step_ff + 8'h01;
      end
    end
  end

  wire step_end = seq_state_ff == ST_RUN && tick && time_ff <= 16'h0001;
  wire take_jump = step_end && dest != 8'h00 &&
                   (jcnt == 10'h000 || jump_used[step_ff] < jcnt);

  // Jump counters, cleared on start
  genvar gi;
  generate
    for (gi = 0; gi < 256; gi = gi + 1) begin : g_jump
      always @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
          jump_used[gi] <= 10'h000;
        end else if (do_start && seq_state_ff == ST_IDLE) begin
          jump_used[gi] <= 10'h000;
        end else if (take_jump && step_ff == gi && jcnt != 10'h000) begin
          jump_used[gi] <= jump_used[gi] + 10'h001;
        end
      end
    end
  endgenerate

  // Sequencer state machine
  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      seq_state_ff <= ST_IDLE;
      step_ff <= 8'h00;
      time_ff <= 16'h0000;
      sync_ff <= 2'h0;
      level_ff <= 16'h0000;
    end else begin
      step_ff <= nxt_step;
      if (!output_enable_ff || do_stop) begin
        seq_state_ff <= ST_IDLE;
        step_ff <= 8'h00;
      end else begin
        case (seq_state_ff)
          ST_IDLE: begin
            if (do_start) begin
              seq_state_ff <= ST_LOAD;
            end
          end
          ST_LOAD: begin
            // Branch during load waits for new word
            if (nxt_step == step_ff) begin
              time_ff <= step_word[`SRCI_F_TIME_LSB +: 16];
              sync_ff <= step_word[`SRCI_F_SYNC_LSB +: 2];
              if (!step_word[`SRCI_F_KEEP]) begin
                level_ff <= step_word[`SRCI_F_LEVEL_LSB +: 16];
              end
              seq_state_ff <= ST_RUN;
            end
          end
          ST_RUN: begin
            if (do_hold) begin
              seq_state_ff <= ST_HOLD;
            end else if (nxt_step != step_ff && !step_end) begin
              seq_state_ff <= ST_LOAD;
            end else if (step_end) begin
              if (term == `SRCI_TERM_STOP) begin
                seq_state_ff <= ST_IDLE;
              end else if (term == `SRCI_TERM_HOLD) begin
                seq_state_ff <= ST_HOLD;
              end else if (take_jump || step_ff != last_step_ff) begin
                seq_state_ff <= ST_LOAD;
              end else begin
                seq_state_ff <= ST_IDLE;
              end
            end else if (tick) begin
              time_ff <= time_ff - 16'h0001;
            end
          end
          ST_HOLD: begin
            if (nxt_step != step_ff) begin
              seq_state_ff <= ST_LOAD;
            end else if (do_start) begin
              seq_state_ff <= ST_RUN;
            end
          end
          default: seq_state_ff <= ST_IDLE;
        endcase
      end
    end
  end

  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      stat_cnt_ff <= 32'h0000_0000;
      power_state_ff <= 1'b0;
      output_state_ff <= 1'b0;
      overload_state_ff <= 1'b0;
      busy_state_ff <= 1'b0;
      sync_bit_low_line_ff <= 1'b0;
      sync_bit_high_line_ff <= 1'b0;
    end else if (stat_cnt_ff == STATUS_MAX) begin
      stat_cnt_ff <= 32'h0000_0000;
      if (pwr_sync_ff[1] == pwr_sync_ff[2]) begin
        power_state_ff <= pwr_sync_ff[2];
      end
      output_state_ff <= output_enable_ff;
      if (ovl_sync_ff[1] == ovl_sync_ff[2]) begin
        overload_state_ff <= ovl_sync_ff[2];
      end
      busy_state_ff <= ctrl_ff[`SRCI_CTRL_BUSY] | clr_busy_ff;
      sync_bit_low_line_ff <= (seq_state_ff == ST_IDLE) ? 1'b0 : sync_ff[0];
      sync_bit_high_line_ff <= (seq_state_ff == ST_IDLE) ? 1'b0 : sync_ff[1];
    end else begin
      stat_cnt_ff <= stat_cnt_ff + 32'h0000_0001;
    end
  end

  // Read data, one cycle after strobe
  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      rdata_ff <= 32'h0000_0000;
    end else if (rd_stb) begin
      case (addr)
        `SRCI_REG_CTRL: rdata_ff <= {29'h0000_0000, ctrl_ff};
        `SRCI_REG_BRANCH: rdata_ff <= {16'h0000, br1_ff, br0_ff};
        `SRCI_REG_STATUS: rdata_ff <= {27'h0000_0000, clr_busy_ff, output_enable_ff,
                                       sync_ff[0], seq_state_ff};
        `SRCI_REG_STEP: rdata_ff <= {16'h0000, time_ff[7:0], step_ff};
        `SRCI_REG_LEVEL: rdata_ff <= {16'h0000, level_ff};
        `SRCI_REG_MEM_ADDR: rdata_ff <= {23'h00_0000, mem_addr_ff};
        `SRCI_REG_LAST_STEP: rdata_ff <= {24'h00_0000, last_step_ff};
        default: rdata_ff <= 32'h0000_0000;
      endcase
    end else begin
      rdata_ff <= 32'h0000_0000;
    end
  end
endmodule // srci_seq_ctrl
`default_nettype wire

// >>> test/srci_seq_ctrl_assertions.sv
// Port checker for the sequence run control block
`include "srci_regs.vh"
`default_nettype none
module srci_seq_ctrl_assertions (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr_stb,
  input wire logic power_on,
  input wire logic power_state_ff,
  input wire logic output_state_ff,
  input wire logic sync_bit_low_line_ff,
  input wire logic sync_bit_high_line_ff,
  input wire logic output_enable_ff,
  input wire logic [1:0] seq_state_ff
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rstn);
  wire logic cmd_wr = wr_stb && addr == `SRCI_REG_CMD;

  property p_start_off;
    cmd_wr && wdata[7:0] == 8'h04 && !output_enable_ff |=> seq_state_ff == 2'h0;
  endproperty
  a_start_off: assert property (p_start_off) else $error("start taken while off");
  property p_start;
    cmd_wr && wdata[7:0] == 8'h04 && output_enable_ff && seq_state_ff == 2'h0
      |=> seq_state_ff == 2'h3 ##1 seq_state_ff == 2'h1;
  endproperty
  a_start: assert property (p_start) else $error("start not run");
  property p_resume;
    cmd_wr && wdata[7:0] == 8'h04 && output_enable_ff && seq_state_ff == 2'h2
      |=> seq_state_ff == 2'h1;
  endproperty
  a_resume: assert property (p_resume) else $error("resume not run");
  property p_stop;
    cmd_wr && wdata[7:0] == 8'h08 |=> seq_state_ff == 2'h0;
  endproperty
  a_stop: assert property (p_stop) else $error("stop not idle");
  property p_hold;
    cmd_wr && wdata[7:0] == 8'h10 && output_enable_ff && seq_state_ff == 2'h1
      |=> seq_state_ff == 2'h2;
  endproperty
  a_hold: assert property (p_hold) else $error("hold not taken");
  property p_off;
    cmd_wr && wdata[0] |=> !output_enable_ff ##1 seq_state_ff == 2'h0;
  endproperty
  a_off: assert property (p_off) else $error("off not taken");
  property p_on;
    cmd_wr && wdata[1:0] == 2'b10 |=> output_enable_ff;
  endproperty
  a_on: assert property (p_on) else $error("on not taken");
  property p_idle_sync;
    (seq_state_ff == 2'h0) [*8] |-> !sync_bit_low_line_ff && !sync_bit_high_line_ff;
  endproperty
  a_idle_sync: assert property (p_idle_sync) else $error("sync not zero");
  property p_out_line;
    $stable(output_enable_ff) [*8] |-> output_state_ff == output_enable_ff;
  endproperty
  a_out_line: assert property (p_out_line) else $error("output line stale");
  property p_pwr_line;
    $stable(power_on) [*8] |-> power_state_ff == power_on;
  endproperty
  a_pwr_line: assert property (p_pwr_line) else $error("power line stale");
  c_run: cover property (seq_state_ff == 2'h1);
  c_hold: cover property (seq_state_ff == 2'h2);
  c_sync: cover property (sync_bit_high_line_ff && !sync_bit_low_line_ff);
endmodule // srci_seq_ctrl_assertions
`default_nettype wire

// >>> test/srci_ext_model.sv
// Model of the external control equipment on the control connector
`default_nettype none
module srci_ext_model (
  input wire logic clk_sys,
  output logic [6:0] ext_in
);
  timeunit 1ns;
  timeprecision 1ps;
  initial ext_in = 7'h7f;
  task automatic pulse(input int idx, input int hold);
    @(posedge clk_sys);
    ext_in <= 7'h7f & ~(7'h01 << idx);
    repeat (hold) @(posedge clk_sys);
    ext_in <= 7'h7f;
    repeat (hold) @(posedge clk_sys);
  endtask
endmodule // srci_ext_model
`default_nettype wire

// >>> test/tb_top.sv
// Self-checking bench for the sequence run control block
`include "srci_regs.vh"
`default_nettype none
`define CHK(n, e, s) begin \
  cmp_count++; \
  if ((s) !== (e)) begin \
    errors++; \
    $display("MISMATCH %s exp %0h got %0h", n, e, s); \
  end \
end
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys = 0, rstn = 0, wr_stb = 0, rd_stb = 0, chk = 0, chk_d = 0;
  logic power_on = 1, overload = 0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0, rd_val, lv_a, lv_b, rdata_ff, exp_q[$], msk_q[$];
  logic [6:0] ext_in;
  logic [1:0] seq_state_ff;
  logic [15:0] level_ff;
  logic pwr_st, out_st, ovl_st, busy_st, sync_lo, sync_hi, out_en;
  integer seed = 32'h585ff535;
  int errors = 0, cmp_count = 0;
  int ext_idx[5] = '{1, 2, 4, 3, 0};
  logic [31:0] ext_exp[5] = '{32'h8, 32'h9, 32'ha, 32'h8, 32'h0};

  always #2 clk_sys = ~clk_sys;

  srci_seq_ctrl #(.SAMPLE_CYC(8), .STATUS_CYC(4), .TICK_CYC(4)) srci_seq_ctrl_i (
    .clk_sys(clk_sys), .rstn(rstn), .addr(addr), .wdata(wdata), .wr_stb(wr_stb),
    .rd_stb(rd_stb), .rdata_ff(rdata_ff), .ext_in(ext_in), .power_on(power_on),
    .overload(overload), .power_state_ff(pwr_st), .output_state_ff(out_st),
    .overload_state_ff(ovl_st), .busy_state_ff(busy_st), .sync_bit_low_line_ff(sync_lo),
    .sync_bit_high_line_ff(sync_hi), .output_enable_ff(out_en), .level_ff(level_ff),
    .seq_state_ff(seq_state_ff));
  srci_ext_model srci_ext_model_i (.clk_sys(clk_sys), .ext_in(ext_in));

  always @(posedge clk_sys) begin
    chk_d <= chk;
    if (chk_d && exp_q.size() > 0) begin
      `CHK("read data", exp_q[0], rdata_ff & msk_q[0])
      void'(exp_q.pop_front());
      void'(msk_q.pop_front());
    end
  end

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    addr <= a;
    wdata <= d;
    wr_stb <= 1'b1;
    @(posedge clk_sys);
    wr_stb <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic c);
    @(posedge clk_sys);
    addr <= a;
    rd_stb <= 1'b1;
    chk <= c;
    @(posedge clk_sys);
    rd_stb <= 1'b0;
    chk <= 1'b0;
    @(posedge clk_sys);
    rd_val = rdata_ff;
  endtask
  task automatic rd_exp(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    exp_q.push_back(e & m);
    msk_q.push_back(m);
    rd(a, 1'b1);
  endtask
  task automatic poll(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    for (int i = 0; i < 400; i++) begin
      rd(a, 1'b0);
      if ((rd_val & m) === e) return;
    end
    errors++;
    $display("MISMATCH poll %0h exp %0h got %0h", a, e, rd_val & m);
    print_verdict();
  endtask
  // Word: term, keep, sync, jump count, dest, level, time
  task automatic step_wr(input logic [7:0] n, input logic [54:0] w);
    wr(`SRCI_REG_MEM_ADDR, {24'h0, n});
    wr(`SRCI_REG_LEVEL, w[31:0]);
    wr(`SRCI_REG_MEM_DATA, {9'h0, w[54:32]});
  endtask
  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  initial begin
    lv_a = $random(seed);
    lv_b = $random(seed);
    repeat (12) @(posedge clk_sys);
    rstn <= 1'b1;
    rd_exp(`SRCI_REG_CTRL, 32'hffffffff, 32'h0);
    rd_exp(`SRCI_REG_LAST_STEP, 32'hffffffff, 32'h1);
    rd_exp(8'h24, 32'hffffffff, 32'h0);
    wr(`SRCI_REG_CMD, 32'h04);
    rd_exp(`SRCI_REG_STATUS, 32'h3, 32'h0);
    $display("test reset and refusal done");
    step_wr(8'h1, {5'h01, 18'h0, lv_a[15:0], 16'h3});
    step_wr(8'h2, {5'h06, 18'h0, lv_b[15:0], 16'hfff});
    step_wr(8'h3, {5'h03, 10'h1, 8'h1, lv_b[15:0], 16'h2});
    wr(`SRCI_REG_LAST_STEP, 32'h3);
    wr(`SRCI_REG_BRANCH, 32'h3);
    wr(`SRCI_REG_CMD, 32'h02);
    wr(`SRCI_REG_CMD, 32'h04);
    poll(`SRCI_REG_STEP, 32'hff, 32'h2);
    rd_exp(`SRCI_REG_LEVEL, 32'hffff, {16'h0, lv_a[15:0]});
    `CHK("level port", lv_a[15:0], level_ff)
    repeat (8) @(posedge clk_sys);
    `CHK("sync lines", 2'h2, {sync_hi, sync_lo})
    wr(`SRCI_REG_CMD, 32'h40);
    rd_exp(`SRCI_REG_STEP, 32'hff, 32'h2);
    wr(`SRCI_REG_CMD, 32'h20);
    poll(`SRCI_REG_STEP, 32'hff, 32'h3);
    poll(`SRCI_REG_STEP, 32'hff, 32'h1);
    poll(`SRCI_REG_STEP, 32'hff, 32'h2);
    wr(`SRCI_REG_CMD, 32'h20);
    poll(`SRCI_REG_STATUS, 32'h3, 32'h0);
    $display("test program run done");
    wr(`SRCI_REG_CMD, 32'h04);
    wr(`SRCI_REG_CMD, 32'h10);
    repeat (40) @(posedge clk_sys);
    rd_exp(`SRCI_REG_STATUS, 32'h3, 32'h2);
    rd_exp(`SRCI_REG_STEP, 32'hff, 32'h1);
    wr(`SRCI_REG_CMD, 32'h04);
    rd_exp(`SRCI_REG_STATUS, 32'h3, 32'h1);
    wr(`SRCI_REG_CMD, 32'h08);
    rd_exp(`SRCI_REG_STATUS, 32'h3, 32'h0);
    $display("test hold done");
    wr(`SRCI_REG_CTRL, 32'h2);
    wr(`SRCI_REG_CMD, 32'h80);
    rd_exp(`SRCI_REG_STATUS, 32'h10, 32'h10);
    repeat (8) @(posedge clk_sys);
    `CHK("busy line", 1'b1, busy_st)
    poll(`SRCI_REG_STATUS, 32'h10, 32'h0);
    wr(`SRCI_REG_CMD, 32'h04);
    poll(`SRCI_REG_STATUS, 32'h3, 32'h0);
    rd_exp(`SRCI_REG_LEVEL, 32'hffff, 32'h0);
    wr(`SRCI_REG_CTRL, 32'h0);
    wr(`SRCI_REG_CMD, 32'h04);
    poll(`SRCI_REG_STEP, 32'hff, 32'h2);
    rd_exp(`SRCI_REG_LEVEL, 32'hffff, {16'h0, lv_a[15:0]});
    wr(`SRCI_REG_CMD, 32'h08);
    $display("test memory banks done");
    wr(`SRCI_REG_CMD, 32'h01);
    srci_ext_model_i.pulse(1, 24);
    rd_exp(`SRCI_REG_STATUS, 32'h8, 32'h0);
    wr(`SRCI_REG_CTRL, 32'h1);
    for (int i = 0; i < 5; i++) begin
      overload <= 1'($random(seed));
      power_on <= 1'($random(seed));
      srci_ext_model_i.pulse(ext_idx[i], 24);
      rd_exp(`SRCI_REG_STATUS, 32'hb, ext_exp[i]);
      `CHK("overload line", overload, ovl_st)
    end
    wr(`SRCI_REG_CTRL, 32'h4);
    repeat (8) @(posedge clk_sys);
    `CHK("busy line", 1'b1, busy_st)
    `CHK("power line", power_on, pwr_st)
    `CHK("output line", 1'b0, out_st)
    $display("test external port done");
    repeat (4) @(posedge clk_sys);
    print_verdict();
  end
endmodule // tb_top

bind srci_seq_ctrl srci_seq_ctrl_assertions srci_seq_ctrl_assertions_i (
  .clk_sys(clk_sys), .rstn(rstn), .addr(addr), .wdata(wdata), .wr_stb(wr_stb),
  .power_on(power_on), .power_state_ff(power_state_ff), .output_state_ff(output_state_ff),
  .sync_bit_low_line_ff(sync_bit_low_line_ff), .sync_bit_high_line_ff(sync_bit_high_line_ff),
  .output_enable_ff(output_enable_ff), .seq_state_ff(seq_state_ff));
`default_nettype wire
